// *** verilog/oga_global_attr.sv ***
// osd global attribute control: registers, display window and pixel outputs
`timescale 1ns/1ps
module oga_global_attr (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic       hsync,
   input  wire logic       vsync,
   input  wire logic       pixel_on,
   input  wire logic       pixel_bg_attr,
   input  wire logic [3:0] attr_bg_color,
   input  wire logic       pixel_fg_attr,
   input  wire logic [3:0] attr_fg_color,
   input  wire logic       pixel_hidden,
   input  wire logic       serial_code_valid,
   input  wire logic [7:0] serial_code,
   output logic      [3:0] rgbi_out,
   output logic            fast_blank_out,
   output logic            translucent_out,
   output logic            contrast_reduce_out,
   output logic            outline_active,
   output logic            smoothing_active,
   output logic            parallel_attr_mode,
   output logic            eighty_char_mode,
   output logic            line_mode_sel,
   output logic [2:0]      box_mode,
   output logic [3:0]      font_subset,
   output logic            triple_g0_mode,
   output logic            second_font_active,
   output logic            double_height_on,
   output logic            double_height_lower,
   output logic            wide_format_sel,
   output logic            in_display_area
);

   // register file
   logic [7:0] default_colors, horizontal_offset, vertical_offset, screen_fill_box_ctrl;
   logic [7:0] font_subset_sel, scroll_ctrl_low, scroll_ctrl_high;
   logic [7:0] display_mode_ctrl_a, display_mode_ctrl_b;
   logic [7:0] next_default_colors, next_horizontal_offset, next_vertical_offset;
   logic [7:0] next_screen_fill_box_ctrl, next_font_subset_sel, next_scroll_ctrl_low;
   logic [7:0] next_scroll_ctrl_high, next_display_mode_ctrl_a, next_display_mode_ctrl_b;
   logic [31:0] next_wb_dat_o;
   logic        next_wb_ack_o;

   // line-latched shadow copies
   logic [7:0] sh_colors, sh_hoff, sh_voff, sh_fill, sh_font, sh_dh, sh_a, sh_b;
   logic [7:0] next_sh_colors, next_sh_hoff, next_sh_voff, next_sh_fill;
   logic [7:0] next_sh_font, next_sh_dh, next_sh_a, next_sh_b;

   // timing
   logic        hsync_d, vsync_d;
   logic [10:0] hcount, next_hcount;
   logic [9:0]  vcount, next_vcount;
   logic        fringe_toggle, next_fringe_toggle;
   logic        font_toggle, next_font_toggle;
   logic        next_hsync_d, next_vsync_d;

   // output next values
   logic [3:0] next_rgbi;
   logic       next_fb, next_translucent_out, next_ht, next_in_area;

   wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
   wire line_start = hsync && !hsync_d;
   wire frame_start = vsync && !vsync_d;

   function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [7:0] addr,
                                          input logic [7:0] match);
      wr_byte = (wr_lane0 && addr == match) ? wb_dat_i[7:0] : cur;
   endfunction

   // register writes and reads
   always_comb begin
      next_default_colors       = wr_byte(default_colors, wb_adr_i, oga_pkg::ADDR_DEFAULT_COLORS);
      next_horizontal_offset    = wr_byte(horizontal_offset, wb_adr_i, oga_pkg::ADDR_HORIZONTAL_OFF);
      next_vertical_offset      = wr_byte(vertical_offset, wb_adr_i, oga_pkg::ADDR_VERTICAL_OFF);
      next_screen_fill_box_ctrl = wr_byte(screen_fill_box_ctrl, wb_adr_i, oga_pkg::ADDR_SCREEN_FILL_BOX);
      next_font_subset_sel      = wr_byte(font_subset_sel, wb_adr_i, oga_pkg::ADDR_FONT_SUBSET_SEL);
      next_scroll_ctrl_low      = wr_byte(scroll_ctrl_low, wb_adr_i, oga_pkg::ADDR_SCROLL_LOW);
      next_scroll_ctrl_high     = wr_byte(scroll_ctrl_high, wb_adr_i, oga_pkg::ADDR_SCROLL_HIGH);
      next_display_mode_ctrl_a  = wr_byte(display_mode_ctrl_a, wb_adr_i, oga_pkg::ADDR_MODE_CTRL_A);
      next_display_mode_ctrl_b  = wr_byte(display_mode_ctrl_b, wb_adr_i, oga_pkg::ADDR_MODE_CTRL_B);
      next_wb_ack_o = bus_req;
      next_wb_dat_o = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         if (wb_adr_i == oga_pkg::ADDR_DEFAULT_COLORS) begin
            next_wb_dat_o[7:0] = default_colors;
         end else if (wb_adr_i == oga_pkg::ADDR_HORIZONTAL_OFF) begin
            next_wb_dat_o[7:0] = horizontal_offset;
         end else if (wb_adr_i == oga_pkg::ADDR_VERTICAL_OFF) begin
            next_wb_dat_o[7:0] = vertical_offset;
         end else if (wb_adr_i == oga_pkg::ADDR_SCREEN_FILL_BOX) begin
            next_wb_dat_o[7:0] = screen_fill_box_ctrl;
         end else if (wb_adr_i == oga_pkg::ADDR_FONT_SUBSET_SEL) begin
            next_wb_dat_o[7:0] = font_subset_sel;
         end else if (wb_adr_i == oga_pkg::ADDR_SCROLL_LOW) begin
            next_wb_dat_o[7:0] = scroll_ctrl_low;
         end else if (wb_adr_i == oga_pkg::ADDR_SCROLL_HIGH) begin
            next_wb_dat_o[7:0] = scroll_ctrl_high;
         end else if (wb_adr_i == oga_pkg::ADDR_MODE_CTRL_A) begin
            next_wb_dat_o[7:0] = display_mode_ctrl_a;
         end else if (wb_adr_i == oga_pkg::ADDR_MODE_CTRL_B) begin
            next_wb_dat_o[7:0] = display_mode_ctrl_b;
         end else if (wb_adr_i == oga_pkg::ADDR_STATUS) begin
            next_wb_dat_o[9:0]   = vcount;
            next_wb_dat_o[10]    = in_display_area;
            next_wb_dat_o[11]    = fringe_toggle;
         end else begin
            next_wb_dat_o = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         default_colors       <= oga_pkg::RESET_VALUE;
         horizontal_offset    <= oga_pkg::RESET_VALUE;
         vertical_offset      <= oga_pkg::RESET_VALUE;
         screen_fill_box_ctrl <= oga_pkg::RESET_VALUE;
         font_subset_sel      <= oga_pkg::RESET_VALUE;
         scroll_ctrl_low      <= oga_pkg::RESET_VALUE;
         scroll_ctrl_high     <= oga_pkg::RESET_VALUE;
         display_mode_ctrl_a  <= oga_pkg::RESET_VALUE;
         display_mode_ctrl_b  <= oga_pkg::RESET_VALUE;
         wb_ack_o             <= 1'b0;
         wb_dat_o             <= 32'h0000_0000;
      end else begin
         default_colors       <= next_default_colors;
         horizontal_offset    <= next_horizontal_offset;
         vertical_offset      <= next_vertical_offset;
         screen_fill_box_ctrl <= next_screen_fill_box_ctrl;
         font_subset_sel      <= next_font_subset_sel;
         scroll_ctrl_low      <= next_scroll_ctrl_low;
         scroll_ctrl_high     <= next_scroll_ctrl_high;
         display_mode_ctrl_a  <= next_display_mode_ctrl_a;
         display_mode_ctrl_b  <= next_display_mode_ctrl_b;
         wb_ack_o             <= next_wb_ack_o;
         wb_dat_o             <= next_wb_dat_o;
      end
   end

   // shadow load, counters and serial toggles
   always_comb begin
      next_hsync_d = hsync;
      next_vsync_d = vsync;
      next_sh_colors = sh_colors;
      next_sh_hoff   = sh_hoff;
      next_sh_voff   = sh_voff;
      next_sh_fill   = sh_fill;
      next_sh_font   = sh_font;
      next_sh_dh     = sh_dh;
      next_sh_a      = sh_a;
      next_sh_b      = sh_b;
      next_fringe_toggle = fringe_toggle;
      next_font_toggle   = font_toggle;
      next_hcount = (hcount == 11'h7ff) ? hcount : hcount + 11'h001;
      next_vcount = vcount;
      if (line_start) begin
         next_sh_colors = default_colors;
         next_sh_hoff   = horizontal_offset;
         next_sh_voff   = vertical_offset;
         next_sh_fill   = screen_fill_box_ctrl;
         next_sh_font   = font_subset_sel;
         next_sh_dh     = scroll_ctrl_high;
         next_sh_a      = display_mode_ctrl_a;
         next_sh_b      = display_mode_ctrl_b;
         next_fringe_toggle = 1'b0;
         next_font_toggle   = 1'b0;
         next_hcount = 11'h000;
         next_vcount = (vcount == 10'h3ff) ? vcount : vcount + 10'h001;
      end else if (serial_code_valid && serial_code == 8'h1b && !sh_b[oga_pkg::BIT_ATTR_FORMAT]) begin
         if (sh_font[oga_pkg::BIT_SECOND_FONT]) begin
            next_font_toggle = !font_toggle;
         end else if (sh_a[oga_pkg::BIT_TOGGLE_OUTL]) begin
            next_fringe_toggle = !fringe_toggle;
         end
      end
      if (frame_start) begin
         next_vcount = 10'h000;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hsync_d <= 1'b0;
         vsync_d <= 1'b0;
         sh_colors <= oga_pkg::RESET_VALUE;
         sh_hoff   <= oga_pkg::RESET_VALUE;
         sh_voff   <= oga_pkg::RESET_VALUE;
         sh_fill   <= oga_pkg::RESET_VALUE;
         sh_font   <= oga_pkg::RESET_VALUE;
         sh_dh     <= oga_pkg::RESET_VALUE;
         sh_a      <= oga_pkg::RESET_VALUE;
         sh_b      <= oga_pkg::RESET_VALUE;
         fringe_toggle <= 1'b0;
         font_toggle   <= 1'b0;
         hcount <= 11'h000;
         vcount <= 10'h000;
      end else begin
         hsync_d <= next_hsync_d;
         vsync_d <= next_vsync_d;
         sh_colors <= next_sh_colors;
         sh_hoff   <= next_sh_hoff;
         sh_voff   <= next_sh_voff;
         sh_fill   <= next_sh_fill;
         sh_font   <= next_sh_font;
         sh_dh     <= next_sh_dh;
         sh_a      <= next_sh_a;
         sh_b      <= next_sh_b;
         fringe_toggle <= next_fringe_toggle;
         font_toggle   <= next_font_toggle;
         hcount <= next_hcount;
         vcount <= next_vcount;
      end
   end

   // display window and pixel colour
   logic [10:0] h_start, h_end;
   logic        v_in, h_in, disp_on, is_fg, is_bg;
   logic [3:0]  full_color, bg_color, fg_color;
   always_comb begin
      disp_on = sh_a[oga_pkg::BIT_DISPLAY_ON];
      h_start = {3'b000, sh_hoff};
      if (sh_a[oga_pkg::BIT_WIDE_FORMAT]) begin
         h_start = h_start + {1'b0, oga_pkg::WIDE_EXTRA_PIXELS};
      end
      h_end = h_start + oga_pkg::LINE_PIXELS_40;
      v_in = (vcount >= {2'b00, sh_voff}) && (vcount < {2'b00, sh_voff} + oga_pkg::PAGE_LINES);
      h_in = (hcount >= h_start) && (hcount < h_end);
      full_color = sh_fill[3:0];
      bg_color = pixel_bg_attr ? attr_bg_color : sh_colors[3:0];
      fg_color = pixel_fg_attr ? attr_fg_color : sh_colors[7:4];
      is_fg = pixel_on && !(pixel_hidden && sh_a[oga_pkg::BIT_CONCEAL]);
      is_bg = !is_fg;
      next_in_area = disp_on && v_in && h_in;
      next_rgbi = 4'h0;
      next_translucent_out = 1'b0;
      next_ht   = 1'b0;
      if (disp_on) begin
         if (!v_in || !h_in) begin
            next_rgbi = full_color;
         end else if (is_fg) begin
            next_rgbi = fg_color;
         end else begin
            next_rgbi = bg_color;
         end
         next_translucent_out = sh_fill[oga_pkg::BIT_TRANSLUCENCY] && (!next_in_area || is_bg);
         next_ht = sh_font[oga_pkg::BIT_HALFTONE_CTRL] && (!next_in_area || is_bg);
      end
      next_fb = disp_on ^ !sh_b[oga_pkg::BIT_FB_POLARITY];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rgbi_out            <= 4'h0;
         fast_blank_out      <= 1'b1;
         translucent_out     <= 1'b0;
         contrast_reduce_out <= 1'b0;
         in_display_area     <= 1'b0;
         outline_active      <= 1'b0;
         smoothing_active    <= 1'b0;
         parallel_attr_mode  <= 1'b0;
         eighty_char_mode    <= 1'b0;
         line_mode_sel       <= 1'b0;
         box_mode            <= 3'h0;
         font_subset         <= 4'h0;
         triple_g0_mode      <= 1'b0;
         second_font_active  <= 1'b0;
         double_height_on    <= 1'b0;
         double_height_lower <= 1'b0;
         wide_format_sel     <= 1'b0;
      end else begin
         rgbi_out            <= next_rgbi;
         fast_blank_out      <= next_fb;
         translucent_out     <= next_translucent_out;
         contrast_reduce_out <= next_ht;
         in_display_area     <= next_in_area;
         outline_active      <= !sh_a[oga_pkg::BIT_EIGHTY_CHARS] &&
                                (sh_a[oga_pkg::BIT_OUTLINE_ALL] || fringe_toggle);
         smoothing_active    <= sh_a[oga_pkg::BIT_SMOOTHING_ALL] && !sh_a[oga_pkg::BIT_EIGHTY_CHARS];
         parallel_attr_mode  <= sh_b[oga_pkg::BIT_ATTR_FORMAT] && !sh_a[oga_pkg::BIT_EIGHTY_CHARS];
         eighty_char_mode    <= sh_a[oga_pkg::BIT_EIGHTY_CHARS];
         line_mode_sel       <= sh_b[oga_pkg::BIT_LINE_MODE];
         box_mode            <= sh_fill[oga_pkg::BOX_LSB +: 3];
         font_subset         <= (sh_font[3:0] > oga_pkg::SUBSET_LAST) ? oga_pkg::SUBSET_LAST : sh_font[3:0];
         triple_g0_mode      <= sh_font[oga_pkg::BIT_TRIPLE_G0];
         second_font_active  <= sh_font[oga_pkg::BIT_TRIPLE_G0] && font_toggle;
         double_height_on    <= sh_dh[oga_pkg::BIT_DOUBLE_HEIGHT];
         double_height_lower <= sh_dh[oga_pkg::BIT_DH_LOWER_HALF];
         wide_format_sel     <= sh_a[oga_pkg::BIT_WIDE_FORMAT];
      end
   end

endmodule

// *** verilog/oga_pkg.sv ***
// constants for the osd global attribute control block
package oga_pkg;
   // register byte addresses (wishbone, 8-bit data in low lane; status reads return 12 bits)
   localparam logic [7:0] ADDR_DEFAULT_COLORS  = 8'hf0;
   localparam logic [7:0] ADDR_HORIZONTAL_OFF  = 8'hf1;
   localparam logic [7:0] ADDR_VERTICAL_OFF    = 8'hf2;
   localparam logic [7:0] ADDR_SCREEN_FILL_BOX = 8'hf3;
   localparam logic [7:0] ADDR_FONT_SUBSET_SEL = 8'hf5;
   localparam logic [7:0] ADDR_SCROLL_LOW      = 8'hf8;
   localparam logic [7:0] ADDR_SCROLL_HIGH     = 8'hf9;
   localparam logic [7:0] ADDR_MODE_CTRL_A     = 8'hfa;
   localparam logic [7:0] ADDR_MODE_CTRL_B     = 8'hfb;
   localparam logic [7:0] ADDR_STATUS          = 8'hfc;
   localparam logic [7:0] RESET_VALUE          = 8'h00;
   // display_mode_ctrl_a fields
   localparam int BIT_DISPLAY_ON    = 0;
   localparam int BIT_WIDE_FORMAT   = 1;
   localparam int BIT_CONCEAL       = 2;
   localparam int BIT_SMOOTHING_ALL = 3;
   localparam int BIT_OUTLINE_ALL   = 4;
   localparam int BIT_TOGGLE_OUTL   = 5;
   localparam int BIT_EIGHTY_CHARS  = 6;
   // display_mode_ctrl_b fields
   localparam int BIT_FB_POLARITY   = 0;
   localparam int BIT_ATTR_FORMAT   = 1;
   localparam int BIT_LINE_MODE     = 2;
   // font_subset_sel fields
   localparam int BIT_SECOND_FONT   = 5;
   localparam int BIT_TRIPLE_G0     = 6;
   localparam int BIT_HALFTONE_CTRL = 7;
   // screen_fill_box_ctrl fields
   localparam int BIT_TRANSLUCENCY  = 7;
   localparam int BOX_LSB           = 4;
   // scroll_ctrl_high fields
   localparam int BIT_DOUBLE_HEIGHT = 0;
   localparam int BIT_DH_LOWER_HALF = 1;
   // geometry
   localparam logic [9:0]  WIDE_EXTRA_PIXELS = 10'h0_040;
   localparam logic [10:0] LINE_PIXELS_40    = 11'h0_190;
   localparam logic [9:0]  PAGE_LINES        = 10'h0_104;
   localparam logic [3:0]  SUBSET_LAST       = 4'he;
endpackage

// *** sim/oga_global_attr_chk.sv ***
// port assertions for the osd global attribute control
`timescale 1ns/1ps
module oga_global_attr_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic hsync,
   input wire logic pixel_on,
   input wire logic pixel_hidden,
   input wire logic fast_blank_out,
   input wire logic translucent_out,
   input wire logic contrast_reduce_out,
   input wire logic outline_active,
   input wire logic smoothing_active,
   input wire logic eighty_char_mode,
   input wire logic wide_format_sel,
   input wire logic line_mode_sel,
   input wire logic in_display_area
);
   logic       hs_d;
   logic       next_hs_d;
   logic [3:0] hs_age;
   logic [3:0] next_hs_age;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // cycles since the last hsync rising edge
   always_comb begin
      next_hs_d = hsync;
      next_hs_age = (hs_age == 4'hf) ? hs_age : hs_age + 4'h1;
      if (!resetn) begin
         next_hs_age = 4'hf;
      end else if (hsync && !hs_d) begin
         next_hs_age = 4'h0;
      end
   end
   always_ff @(posedge clk) begin
      hs_d <= next_hs_d;
      hs_age <= next_hs_age;
   end
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_latency: assert property (bus_req |=> ack_pulse)
      else $error("ack not a single pulse one cycle after request");
   chk_no_stray_ack: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   chk_mode_at_line: assert property (($changed(wide_format_sel) || $changed(eighty_char_mode)
      || $changed(line_mode_sel)) |-> hs_age <= 4'h3) else $error("mode changed away from line start");
   chk_fg_translucent: assert property (pixel_on && !pixel_hidden && in_display_area |=>
      !translucent_out || !in_display_area) else $error("translucent during foreground");
   chk_fg_halftone: assert property (pixel_on && !pixel_hidden && in_display_area |=>
      !contrast_reduce_out || !in_display_area) else $error("half tone during foreground");
   chk_eighty_smooth: assert property (eighty_char_mode && $past(eighty_char_mode) |-> !smoothing_active)
      else $error("rounding in eighty char mode");
   chk_eighty_fringe: assert property (eighty_char_mode && $past(eighty_char_mode) |-> !outline_active)
      else $error("fringe in eighty char mode");
   chk_reset_state: assert property (disable iff (1'b0) !resetn |=> fast_blank_out && !translucent_out
      && !in_display_area && !wb_ack_o) else $error("outputs not idle after reset");
endmodule
bind oga_global_attr oga_global_attr_chk oga_global_attr_chk_i (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hsync(hsync), .pixel_on(pixel_on), .pixel_hidden(pixel_hidden),
   .fast_blank_out(fast_blank_out),
   .translucent_out(translucent_out), .contrast_reduce_out(contrast_reduce_out), .outline_active(outline_active),
   .smoothing_active(smoothing_active), .eighty_char_mode(eighty_char_mode), .wide_format_sel(wide_format_sel),
   .line_mode_sel(line_mode_sel), .in_display_area(in_display_area));

// *** sim/oga_video_sink.sv ***
// video processor stand-in counting mixing outputs and area timing
`timescale 1ns/1ps
module oga_video_sink (
   input  wire logic clk,
   input  wire logic hsync,
   input  wire logic translucent_out,
   input  wire logic contrast_reduce_out,
   input  wire logic in_display_area,
   output int        translucent_out_cycles,
   output int        halftone_cycles,
   output int        area_cycles,
   output int        area_start
);
   logic hs_d;
   logic area_d;
   int   hcnt;
   initial begin
      {hs_d, area_d, hcnt, translucent_out_cycles, halftone_cycles, area_cycles, area_start} = '0;
   end
   always @(posedge clk) begin
      hs_d <= hsync;
      area_d <= in_display_area;
      hcnt <= (hsync && !hs_d) ? 0 : hcnt + 1;
      translucent_out_cycles <= translucent_out_cycles + int'(translucent_out === 1'b1);
      halftone_cycles <= halftone_cycles + int'(contrast_reduce_out === 1'b1);
      area_cycles <= area_cycles + int'(in_display_area === 1'b1);
      if (in_display_area === 1'b1 && area_d !== 1'b1) begin
         area_start <= hcnt;
      end
   end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the osd global attribute control
`timescale 1ns/1ps
module testbench;
   logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hsync, vsync, pixel_on, pixel_bg_attr;
   logic        pixel_fg_attr, pixel_hidden, serial_code_valid, fast_blank_out, translucent_out;
   logic        contrast_reduce_out, outline_active, smoothing_active, parallel_attr_mode, eighty_char_mode;
   logic        line_mode_sel, triple_g0_mode, second_font_active, double_height_on, double_height_lower;
   logic        wide_format_sel, in_display_area;
   logic [2:0]  box_mode;
   logic [3:0]  wb_sel_i, attr_bg_color, attr_fg_color, rgbi_out, font_subset;
   logic [7:0]  wb_adr_i, serial_code, d;
   logic [31:0] wb_dat_i, wb_dat_o, em, pe;
   int          translucent_out_cycles, halftone_cycles, area_cycles, area_start, err_total, tests_run, t0, a0, s1;
   logic [7:0]  img [256];
   logic [7:0]  addrs [9];
   logic [31:0] exp_q [$];
   oga_global_attr oga_global_attr_i (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .hsync, .vsync, .pixel_on, .pixel_bg_attr, .attr_bg_color, .pixel_fg_attr,
      .attr_fg_color, .pixel_hidden, .serial_code_valid, .serial_code, .rgbi_out, .fast_blank_out, .translucent_out,
      .contrast_reduce_out, .outline_active, .smoothing_active, .parallel_attr_mode, .eighty_char_mode,
      .line_mode_sel, .box_mode, .font_subset, .triple_g0_mode, .second_font_active, .double_height_on,
      .double_height_lower, .wide_format_sel, .in_display_area);
   oga_video_sink oga_video_sink_i (.clk, .hsync, .translucent_out, .contrast_reduce_out, .in_display_area,
      .translucent_out_cycles, .halftone_cycles, .area_cycles, .area_start);
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, err_total + exp_q.size());
      if (err_total == 0 && exp_q.size() == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
      int n;
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, adr, sel};
      wb_dat_i <= {24'h00_0000, dat};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (n >= 20) begin
         err_total++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
      foreach (addrs[i]) if (addrs[i] == adr && sel[0]) img[adr] = dat;
      wb_cycle(1'b1, adr, dat, sel);
   endtask
   task automatic rd(input logic [7:0] adr);
      exp_q.push_back({24'h00_0000, img[adr]});
      wb_cycle(1'b0, adr, 8'h00, 4'hf);
   endtask
   task automatic line(input int len);
      hsync <= 1'b1;
      repeat (4) @(posedge clk);
      hsync <= 1'b0;
      repeat (len) @(posedge clk);
   endtask
   function automatic logic [31:0] exp_modes();
      logic [7:0] a, b, f, x, s;
      a = img[oga_pkg::ADDR_MODE_CTRL_A];
      b = img[oga_pkg::ADDR_MODE_CTRL_B];
      f = img[oga_pkg::ADDR_FONT_SUBSET_SEL];
      x = img[oga_pkg::ADDR_SCREEN_FILL_BOX];
      s = img[oga_pkg::ADDR_SCROLL_HIGH];
      return {16'h0000, a[3] & ~a[6], a[0] ? b[0] : ~b[0], a[1], a[6], b[1] & ~a[6], b[2], x[6:4], f[3:0], f[6],
         s[0], s[1]};
   endfunction
   function automatic logic [31:0] seen_modes();
      return {16'h0000, smoothing_active, fast_blank_out, wide_format_sel, eighty_char_mode, parallel_attr_mode,
         line_mode_sel,
         box_mode, font_subset, triple_g0_mode, double_height_on, double_height_lower};
   endfunction
   always @(posedge clk) begin
      {pixel_on, pixel_bg_attr, attr_bg_color, pixel_fg_attr, attr_fg_color, pixel_hidden, serial_code_valid,
         serial_code} <= 21'($urandom);
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         cmp("read data", (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxx_xxxx, wb_dat_o);
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      void'($urandom(95044));
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, hsync, vsync} = '0;
      {pixel_on, pixel_bg_attr, attr_bg_color, pixel_fg_attr, attr_fg_color, pixel_hidden} = '0;
      {serial_code_valid, serial_code, err_total, tests_run} = '0;
      foreach (img[i]) img[i] = 8'h00;
      addrs = '{oga_pkg::ADDR_DEFAULT_COLORS, oga_pkg::ADDR_HORIZONTAL_OFF, oga_pkg::ADDR_VERTICAL_OFF,
         oga_pkg::ADDR_SCREEN_FILL_BOX, oga_pkg::ADDR_FONT_SUBSET_SEL, oga_pkg::ADDR_SCROLL_LOW,
         oga_pkg::ADDR_SCROLL_HIGH, oga_pkg::ADDR_MODE_CTRL_A, oga_pkg::ADDR_MODE_CTRL_B};
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      foreach (addrs[i]) rd(addrs[i]);
      for (int k = 0; k < 24; k++) begin
         pe = exp_modes();
         foreach (addrs[i]) begin
            d = 8'($urandom);
            if (addrs[i] == oga_pkg::ADDR_FONT_SUBSET_SEL && d[3:0] == 4'hf) d[3:0] = 4'he;
            wr(addrs[i], d, (k % 5 == 3) ? 4'he : 4'hf);
         end
         wr(8'he0 + 8'($urandom_range(15, 0)), 8'($urandom), 4'hf);
         rd(8'he0 + 8'($urandom_range(15, 0)));
         foreach (addrs[i]) rd(addrs[i]);
         cmp("modes before line", pe, seen_modes());
         line(6);
         cmp("modes after line", exp_modes(), seen_modes());
      end
      wr(oga_pkg::ADDR_MODE_CTRL_B, 8'h00, 4'h1);
      wr(oga_pkg::ADDR_SCROLL_HIGH, 8'h00, 4'h1);
      wr(oga_pkg::ADDR_FONT_SUBSET_SEL, 8'h80, 4'h1);
      wr(oga_pkg::ADDR_SCREEN_FILL_BOX, 8'h8c, 4'h1);
      wr(oga_pkg::ADDR_VERTICAL_OFF, 8'h02, 4'h1);
      for (int w = 0; w < 3; w++) begin
         wr(oga_pkg::ADDR_HORIZONTAL_OFF, (w == 2) ? 8'h14 : 8'h0a, 4'h1);
         wr(oga_pkg::ADDR_MODE_CTRL_A, (w == 0) ? 8'h00 : ((w == 1) ? 8'h01 : 8'h03), 4'h1);
         line(6);
         t0 = translucent_out_cycles;
         pe = 32'(halftone_cycles);
         a0 = area_cycles;
         vsync <= 1'b1;
         repeat (4) @(posedge clk);
         vsync <= 1'b0;
         repeat (5) line(480);
         repeat (4) @(posedge clk);
         cmp("translucent seen", 32'(w > 0), 32'(translucent_out_cycles > t0));
         cmp("half tone seen", 32'(w > 0), 32'(halftone_cycles > int'(pe)));
         cmp("area size", 32'((w > 0) ? 4 * oga_pkg::LINE_PIXELS_40 : 0), 32'(area_cycles - a0));
         cmp("full colour", 32'((w > 0) ? 4'hc : 4'h0), 32'(rgbi_out));
         if (w == 1) s1 = area_start;
         if (w == 2) cmp("area shift", 32'(8'h14 - 8'h0a) + 32'(oga_pkg::WIDE_EXTRA_PIXELS), 32'(area_start - s1));
      end
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      foreach (addrs[i]) img[addrs[i]] = 8'h00;
      rd(oga_pkg::ADDR_MODE_CTRL_A);
      cmp("modes after reset", exp_modes(), seen_modes());
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule
